// ==== src/sltc_top.sv ====
// Transfer control of a full-duplex serial link, reached over APB.
//
// How it works
// - Data write loads characters, starts transmitter.
// - Data write while transmitting is refused, busy.
// - Transmit busy set by write, cleared at end.
// - Transmit done set at end, cleared by next start or interface reset.
// - Finished transmit block raises transmit interrupt.
// - Receiver listens only while count is valid, fills next slot.
// - Full receive block raises receive interrupt.
// - Live error bits OR all characters of the current block.
// - Unread data overwritten sets register overrun.
// - Every mapped access returns two-bit condition code.
// - Five conditions count as errors.
// - Data read snapshots errors into stored bits.
// - Receive busy from start bit to block end.
// - Receive done set at block end, read clears.
// - Busy and done flags always readable.
// - Block count is four bits, four slots.
`timescale 1ns/100ps
module sltc_top
    import sltc_pkg::*;
#(
    parameter int NCHARS = MAX_CHARS
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic      [CHAR_W-1:0]      tx_char,
    output logic                        tx_char_valid,
    input  wire logic                   tx_char_ready,
    input  wire logic                   rx_start_bit,
    input  wire logic                   rx_char_valid,
    input  wire logic [CHAR_W-1:0]      rx_char,
    input  wire logic                   rx_parity_error,
    input  wire logic                   rx_framing_error,
    input  wire logic                   rx_hw_overrun,
    output logic      [1:0]             cond_code,
    output logic                        tx_complete_irq,
    output logic                        rx_complete_irq
);
    generate
        if (NCHARS < 1 || NCHARS > 4) begin : g_bad_nchars
            $error("NCHARS must lie between 1 and 4");
        end
    endgenerate

    logic               rst_sync1_q;
    logic               rst_n_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic [1:0]         cond_q;
    logic               tx_irq_q;
    logic               rx_irq_q;
    logic [COUNT_W-1:0] count_q;
    logic [31:0]        txdata_q;
    logic               tx_done_q;
    logic               rx_done_q;
    logic               reg_ovr_q;
    logic [3:0]         stored_err_q;
    logic               tx_busy;
    logic               tx_fin;
    logic               rx_busy;
    logic               rx_fin;
    logic [31:0]        rx_data;
    logic [ERR_W-1:0]   live_err;
    logic               access;
    logic               wr_ctrl;
    logic               wr_data;
    logic               rd_data;
    logic               tx_start;
    logic               count_ok;
    logic               mapped;
    logic               any_error;
    logic [31:0]        status;

    // Flags of the link accept a count only within the slots built here.
    function automatic logic count_valid(input logic [COUNT_W-1:0] c);
        count_valid = (c != '0) && (c <= COUNT_W'(NCHARS));
    endfunction : count_valid

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync1_q <= 1'b0;
            rst_n_q     <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_n_q     <= rst_sync1_q;
        end
    end

    // One wait state: the access is taken in its first access cycle.
    assign access   = psel && penable && !pready_q;
    assign mapped   = (paddr == OFS_CTRL) || (paddr == OFS_TXDATA) ||
                      (paddr == OFS_RXDATA) || (paddr == OFS_COND);
    assign wr_ctrl  = access && pwrite && paddr == OFS_CTRL;
    assign wr_data  = access && pwrite && paddr == OFS_TXDATA;
    assign rd_data  = access && !pwrite && paddr == OFS_RXDATA;
    assign count_ok = count_valid(count_q);
    assign tx_start = wr_data && !tx_busy && count_ok;

    // Overrun and invalid count both count as detectable errors.
    assign any_error = (|live_err) || reg_ovr_q || !count_ok;

    always_comb begin
        status                                  = WORD_ZERO;
        status[F_COUNT_LO +: COUNT_W]           = count_q;
        status[F_TX_BUSY]                       = tx_busy;
        status[F_TX_DONE]                       = tx_done_q;
        status[F_RX_BUSY]                       = rx_busy;
        status[F_RX_DONE]                       = rx_done_q;
        status[F_STORED_LO +: 4]                = stored_err_q;
        status[F_LIVE_LO +: ERR_W]              = live_err;
        status[F_REG_OVR]                       = reg_ovr_q;
        status[F_BAD_COUNT]                     = !count_ok;
    end

    sltc_tx_seq #(
        .NCHARS       (NCHARS)
    ) u_tx (
        .clk          (sys_clk),
        .rst_n        (rst_n_q),
        .start        (tx_start),
        // The sequencer takes the bus word itself: the register copy is
        // loaded on the same edge and would still hold the previous block.
        .data         (pwdata),
        .count        (count_q),
        .char_ready   (tx_char_ready),
        .char_q       (tx_char),
        .char_valid_q (tx_char_valid),
        .busy_q       (tx_busy),
        .done_q       (tx_fin)
    );

    sltc_rx_collect #(
        .NCHARS       (NCHARS)
    ) u_rx (
        .clk          (sys_clk),
        .rst_n        (rst_n_q),
        .enable       (count_ok),
        .count        (count_q),
        .start_bit    (rx_start_bit),
        .char_valid   (rx_char_valid),
        .char_in      (rx_char),
        .char_err     ({rx_hw_overrun, rx_framing_error, rx_parity_error}),
        .data_q       (rx_data),
        .live_err     (live_err),
        .busy_q       (rx_busy),
        .done_q       (rx_fin)
    );

    // Bus answer.
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= WORD_ZERO;
        end else begin
            pready_q  <= access;
            pslverr_q <= access && !mapped;
            if (access && !pwrite) begin
                case (paddr)
                    OFS_CTRL:   prdata_q <= status;
                    OFS_TXDATA: prdata_q <= txdata_q;
                    OFS_RXDATA: prdata_q <= rx_data;
                    OFS_COND:   prdata_q <= {30'h0000_0000, cond_q};
                    default:    prdata_q <= WORD_ZERO;
                endcase
            end else begin
                prdata_q <= WORD_ZERO;
            end
        end
    end

    // Control word and transmit data.
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            count_q  <= COUNT_RESET;
            txdata_q <= WORD_ZERO;
        end else begin
            if (wr_ctrl) begin
                count_q <= pwdata[F_COUNT_LO +: COUNT_W];
            end
            if (tx_start) begin
                txdata_q <= pwdata;
            end
        end
    end

    // Transfer flags; a hardware set beats a simultaneous clear.
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_done_q <= 1'b0;
            rx_done_q <= 1'b0;
            reg_ovr_q <= 1'b0;
        end else begin
            if (tx_fin) begin
                tx_done_q <= 1'b1;
            end else if (tx_start || (wr_ctrl && pwdata[F_IF_RESET])) begin
                tx_done_q <= 1'b0;
            end
            if (rx_fin) begin
                rx_done_q <= 1'b1;
            end else if (rd_data) begin
                rx_done_q <= 1'b0;
            end
            if (rx_char_valid && count_ok && rx_done_q && !rd_data) begin
                reg_ovr_q <= 1'b1;
            end else if (wr_ctrl && pwdata[F_IF_RESET]) begin
                reg_ovr_q <= 1'b0;
            end
        end
    end

    // Stored error snapshot taken only on data reads.
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stored_err_q <= 4'h0;
        end else if (rd_data) begin
            stored_err_q <= {reg_ovr_q, live_err};
        end
    end

    // Condition code of the most recent mapped access.
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cond_q <= 2'h0;
        end else if (access && mapped) begin
            cond_q[CC_BUSY]  <= wr_data ? (tx_busy || !count_ok)
                                        : (tx_busy || rx_busy);
            cond_q[CC_ERROR] <= any_error;
        end
    end

    // Completion pulses toward the host, one cycle each.
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_irq_q <= 1'b0;
            rx_irq_q <= 1'b0;
        end else begin
            tx_irq_q <= tx_fin;
            rx_irq_q <= rx_fin;
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign cond_code       = cond_q;
    assign tx_complete_irq = tx_irq_q;
    assign rx_complete_irq = rx_irq_q;
endmodule : sltc_top

// ==== src/sltc_pkg.sv ====
// Constants shared by the serial link transfer control block.
package sltc_pkg;
    localparam int          CHAR_W         = 8;
    localparam int          MAX_CHARS      = 4;
    localparam int          COUNT_W        = 4;
    localparam int          ERR_W          = 3;
    // Register byte offsets on the APB bus.
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_TXDATA     = 8'h04;
    localparam logic [7:0]  OFS_RXDATA     = 8'h08;
    localparam logic [7:0]  OFS_COND       = 8'h0c;
    // Field positions in the control/status word.
    localparam int          F_COUNT_LO     = 0;
    localparam int          F_TX_BUSY      = 8;
    localparam int          F_TX_DONE      = 9;
    localparam int          F_RX_BUSY      = 10;
    localparam int          F_RX_DONE      = 11;
    localparam int          F_STORED_LO    = 20;
    localparam int          F_LIVE_LO      = 24;
    localparam int          F_REG_OVR      = 27;
    localparam int          F_BAD_COUNT    = 28;
    localparam int          F_IF_RESET     = 31;
    // Condition code bits.
    localparam int          CC_BUSY        = 0;
    localparam int          CC_ERROR       = 1;
    localparam logic [3:0]  COUNT_RESET    = 4'h1;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
endpackage : sltc_pkg

// ==== src/sltc_tx_seq.sv ====
// Transmit sequencer: hands a block of characters to the serializer.
`timescale 1ns/100ps
module sltc_tx_seq
    import sltc_pkg::*;
#(
    parameter int NCHARS = MAX_CHARS
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   start,
    input  wire logic [31:0]            data,
    input  wire logic [COUNT_W-1:0]     count,
    input  wire logic                   char_ready,
    output logic      [CHAR_W-1:0]      char_q,
    output logic                        char_valid_q,
    output logic                        busy_q,
    output logic                        done_q
);
    typedef enum logic [1:0] {
        SLTC_TX_IDLE = 2'b01,
        SLTC_TX_SEND = 2'b10
    } sltc_tx_state_t;

    sltc_tx_state_t     state_q;
    logic [31:0]        buf_q;
    logic [COUNT_W-1:0] left_q;
    logic [1:0]         idx_q;

    function automatic logic [CHAR_W-1:0] pick(input logic [31:0] w,
                                              input logic [1:0]  i);
        pick = w[i*CHAR_W +: CHAR_W];
    endfunction : pick

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= SLTC_TX_IDLE;
            buf_q        <= WORD_ZERO;
            left_q       <= '0;
            idx_q        <= 2'h0;
            char_q       <= '0;
            char_valid_q <= 1'b0;
            busy_q       <= 1'b0;
            done_q       <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                SLTC_TX_IDLE: begin
                    if (start) begin
                        buf_q        <= data;
                        left_q       <= count;
                        idx_q        <= 2'h0;
                        char_q       <= pick(data, 2'h0);
                        char_valid_q <= 1'b1;
                        busy_q       <= 1'b1;
                        state_q      <= SLTC_TX_SEND;
                    end
                end
                SLTC_TX_SEND: begin
                    if (char_ready) begin
                        if (left_q == COUNT_W'(1)) begin
                            char_valid_q <= 1'b0;
                            busy_q       <= 1'b0;
                            done_q       <= 1'b1;
                            state_q      <= SLTC_TX_IDLE;
                        end else begin
                            idx_q  <= idx_q + 2'h1;
                            char_q <= pick(buf_q, idx_q + 2'h1);
                            left_q <= left_q - COUNT_W'(1);
                        end
                    end
                end
                default: state_q <= SLTC_TX_IDLE;
            endcase
        end
    end
endmodule : sltc_tx_seq

// ==== src/sltc_rx_collect.sv ====
// Receive collector: fills character slots and merges their error flags.
`timescale 1ns/100ps
module sltc_rx_collect
    import sltc_pkg::*;
#(
    parameter int NCHARS = MAX_CHARS
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   enable,
    input  wire logic [COUNT_W-1:0]     count,
    input  wire logic                   start_bit,
    input  wire logic                   char_valid,
    input  wire logic [CHAR_W-1:0]      char_in,
    input  wire logic [ERR_W-1:0]       char_err,
    output logic      [31:0]            data_q,
    output logic      [ERR_W-1:0]       live_err,
    output logic                        busy_q,
    output logic                        done_q
);
    logic [COUNT_W-1:0] got_q;
    logic [ERR_W-1:0]   slot_err_q [NCHARS];
    logic [NCHARS-1:0]  slot_used_q;
    logic               take;
    logic               last;

    assign take = enable && char_valid;
    assign last = (got_q + COUNT_W'(1)) == count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            got_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (take && last) begin
                got_q  <= '0;
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end else begin
                if (take) begin
                    got_q <= got_q + COUNT_W'(1);
                end
                if (enable && start_bit) begin
                    busy_q <= 1'b1;
                end
            end
        end
    end

    // A new block starts by forgetting the previous block's slots.
    generate
        for (genvar s = 0; s < NCHARS; s++) begin : g_slot
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    data_q[s*CHAR_W +: CHAR_W] <= '0;
                    slot_err_q[s]              <= '0;
                    slot_used_q[s]             <= 1'b0;
                end else if (take && got_q == COUNT_W'(s)) begin
                    data_q[s*CHAR_W +: CHAR_W] <= char_in;
                    slot_err_q[s]              <= char_err;
                    slot_used_q[s]             <= 1'b1;
                end else if (take && got_q == '0) begin
                    slot_used_q[s] <= 1'b0;
                end
            end
        end
        if (NCHARS * CHAR_W < 32) begin : g_pad
            assign data_q[31:NCHARS*CHAR_W] = '0;
        end
    endgenerate

    always_comb begin
        live_err = '0;
        for (int s = 0; s < NCHARS; s++) begin
            if (slot_used_q[s]) begin
                live_err = live_err | slot_err_q[s];
            end
        end
    end
endmodule : sltc_rx_collect

// ==== tb/sltc_chk_properties.sv ====
// Concurrent checks on the ports of the transfer control block.
`timescale 1ns/100ps
module sltc_chk
    import sltc_pkg::*;
#(
    parameter int NCHARS = MAX_CHARS
) (
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [CHAR_W-1:0] tx_char,
    input wire logic              tx_char_valid,
    input wire logic              tx_char_ready,
    input wire logic              tx_complete_irq,
    input wire logic              rx_complete_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic take;
    logic mapped;
    logic acc;
    assign take = psel && penable && !pready;
    assign mapped = paddr inside {OFS_CTRL, OFS_TXDATA, OFS_RXDATA, OFS_COND};
    assign acc = tx_char_valid && tx_char_ready;
    AST_ONE_WAIT: assert property (take |=> pready)
        else $error("access not answered after one wait state");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_UNMAPPED: assert property (take && !mapped |=> pslverr)
        else $error("unmapped access not flagged");
    AST_MAPPED: assert property (take && mapped |=> !pslverr)
        else $error("mapped access flagged as error");
    AST_IDLE_DATA: assert property (!pready |-> prdata == WORD_ZERO)
        else $error("read data not zero outside an answer");
    AST_TX_HOLD: assert property (tx_char_valid && !tx_char_ready
        |=> tx_char_valid && $stable(tx_char))
        else $error("character withdrawn before acceptance");
    AST_TX_START: assert property ($rose(tx_char_valid)
        |-> $past(take && pwrite && paddr == OFS_TXDATA))
        else $error("character offered without a data write");
    AST_TX_IRQ: assert property (tx_complete_irq
        |-> $past(acc, 2) && !tx_char_valid)
        else $error("transmit interrupt not tied to last character");
    AST_TX_IRQ_PULSE: assert property (tx_complete_irq |=> !tx_complete_irq)
        else $error("transmit interrupt longer than one cycle");
    AST_RX_IRQ_PULSE: assert property (rx_complete_irq |=> !rx_complete_irq)
        else $error("receive interrupt longer than one cycle");
    COV_TX_IRQ: cover property (tx_complete_irq);
    COV_RX_IRQ: cover property (rx_complete_irq);
    COV_UNMAPPED: cover property (take && !mapped);
endmodule : sltc_chk

bind sltc_top sltc_chk #(.NCHARS(NCHARS)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .tx_complete_irq(tx_complete_irq),
    .rx_complete_irq(rx_complete_irq)
);

// ==== tb/sltc_far.sv ====
// Far-side model: a serializer taking characters and a receiver feeding them.
`timescale 1ns/100ps
module sltc_far
    import sltc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [CHAR_W-1:0] tx_char,
    input  wire logic              tx_char_valid,
    output logic                   tx_char_ready,
    output logic                   rx_start_bit,
    output logic                   rx_char_valid,
    output logic      [CHAR_W-1:0] rx_char,
    output logic      [ERR_W-1:0]  rx_err
);
    int                stall = 0;
    int                wait_q = 0;
    logic [CHAR_W-1:0] txlog[$];
    initial begin
        tx_char_ready = 1'b0;
        rx_start_bit = 1'b0;
        rx_char_valid = 1'b0;
        rx_char = 8'h5a;
        rx_err = 3'h0;
    end
    // A stall of some cycles per character keeps the sender busy long
    // enough for the host to collide with it.
    always @(posedge clk) begin
        if (tx_char_valid && tx_char_ready) begin
            txlog.push_back(tx_char);
            tx_char_ready <= 1'b0;
            wait_q <= 0;
        end else if (tx_char_valid && wait_q >= stall) begin
            tx_char_ready <= 1'b1;
        end else if (tx_char_valid) begin
            wait_q <= wait_q + 1;
        end
    end
    // Outside the valid pulse the data lines show the inverse, not a copy.
    task send(input logic [CHAR_W-1:0] c, input logic [ERR_W-1:0] e);
        @(posedge clk);
        rx_start_bit <= 1'b1;
        @(posedge clk);
        rx_start_bit <= 1'b0;
        repeat (8) @(posedge clk);
        rx_char_valid <= 1'b1;
        rx_char <= c;
        rx_err <= e;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        rx_char <= ~c;
        rx_err <= ~e;
    endtask : send
endmodule : sltc_far

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial link transfer control block.
`timescale 1ns/100ps
module tb_top;
    import sltc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, serr, tx_char_valid, tx_char_ready;
    logic        rx_start_bit, rx_char_valid, tx_complete_irq, rx_complete_irq;
    logic [7:0]  tx_char, rx_char;
    logic [2:0]  rx_err;
    logic [1:0]  cond_code;
    int          miscompares = 0, n_tests = 0, cyc = 0, txi = 0, rxi = 0;

    always #12.5 sys_clk = ~sys_clk;

    sltc_top #(.NCHARS(MAX_CHARS)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_char(tx_char),
        .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready),
        .rx_start_bit(rx_start_bit), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .rx_parity_error(rx_err[0]),
        .rx_framing_error(rx_err[1]), .rx_hw_overrun(rx_err[2]),
        .cond_code(cond_code), .tx_complete_irq(tx_complete_irq),
        .rx_complete_irq(rx_complete_irq)
    );
    sltc_far far (
        .clk(sys_clk), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
        .tx_char_ready(tx_char_ready), .rx_start_bit(rx_start_bit),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_err(rx_err)
    );

    task print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk) begin
        cyc++;
        if (tx_complete_irq === 1'b1) txi++;
        if (rx_complete_irq === 1'b1) rxi++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, exp, m);
        n_tests++;
        if ((got & m) !== (exp & m)) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the pready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wirq(ref int c, input int n);
        for (int i = 0; i < 3000 && c < n; i++) @(posedge sys_clk);
        chk(c, n, '1);
    endtask : wirq

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'(COUNT_RESET), '1);
        apb(1, 8'h10, '1);
        chk({31'h0, serr}, 1, '1);
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'(COUNT_RESET), '1);
        far.stall = 10;
        apb(1, OFS_CTRL, 3);
        apb(1, OFS_TXDATA, 32'h4433_2211);
        chk({30'h0, cond_code}, 0, 3);
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'h103, 32'hfff);
        apb(1, OFS_TXDATA, 32'h7766_5555);
        chk({30'h0, cond_code}, 1, 3);
        apb(0, OFS_COND, 0);
        chk(rd, 1, '1);
        wirq(txi, 1);
        repeat (30) @(posedge sys_clk);
        chk(far.txlog.size(), 3, '1);
        for (int i = 0; i < 3; i++) chk(far.txlog[i], 8'h11 * (i + 1), '1);
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'h203, 32'hfff);
        far.stall = 0;
        apb(1, OFS_CTRL, 4);
        apb(1, OFS_TXDATA, 32'hd4c3_b2a1);
        apb(0, OFS_CTRL, 0);
        chk(rd, 0, 32'h200);
        wirq(txi, 2);
        chk(far.txlog.size(), 7, '1);
        chk(far.txlog[6], 8'hd4, '1);
        apb(1, OFS_CTRL, 3);
        far.send(8'haa, 3'h0);
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'h400, 32'hc00);
        far.send(8'hbb, 3'h1);
        far.send(8'hcc, 3'h0);
        wirq(rxi, 1);
        for (int k = 0; k < 2; k++) begin
            apb(0, OFS_CTRL, 0);
            chk(rd, 32'h0100_0803, 32'h1f00_0c0f);
        end
        apb(0, OFS_RXDATA, 0);
        chk(rd, 32'h00cc_bbaa, 32'h00ff_ffff);
        chk({30'h0, cond_code}, 2, 2);
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'h0010_0000, 32'h00f0_0800);
        apb(1, OFS_CTRL, 1);
        for (int i = 0; i < 3; i++) begin
            far.send(8'h40 + 8'(i), 3'(1 << i));
            wirq(rxi, 2 + i);
            apb(0, OFS_CTRL, 0);
            chk(rd, 32'h1 << (24 + i), 32'h0700_0000);
            apb(0, OFS_RXDATA, 0);
            chk(rd, 32'h40 + i, 32'hff);
            apb(0, OFS_CTRL, 0);
            chk(rd, 32'h1 << (20 + i), 32'h0070_0000);
        end
        far.send(8'h51, 3'h0);
        wirq(rxi, 5);
        far.send(8'h52, 3'h0);
        wirq(rxi, 6);
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'h0800_0000, 32'h0800_0000);
        chk({30'h0, cond_code}, 2, 2);
        apb(0, OFS_RXDATA, 0);
        chk(rd, 32'h52, 32'hff);
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'h0080_0000, 32'h0080_0000);
        apb(1, OFS_CTRL, 32'h8000_0001);
        apb(0, OFS_CTRL, 0);
        chk(rd, 0, 32'h0800_0200);
        // Counts just below and just above the valid range must lock out transfers.
        for (int k = 0; k < 2; k++) begin
            apb(1, OFS_CTRL, k * 5);
            apb(0, OFS_CTRL, 0);
            chk(rd, 32'h1000_0000, 32'h1000_0000);
            apb(1, OFS_TXDATA, 32'h0909_0909);
            chk({30'h0, cond_code}, 3, 3);
            far.send(8'h66, 3'h0);
        end
        repeat (20) @(posedge sys_clk);
        chk(rxi, 6, '1);
        chk(far.txlog.size(), 7, '1);
        apb(1, OFS_CTRL, 1);
        apb(0, OFS_CTRL, 0);
        chk(rd, 1, 32'h1000_000f);
        print_verdict();
    end
endmodule : tb_top
